// File: verilog/uerx_regs.vh
// register offsets, field positions and encodings of the endpoint rx channel
`ifndef UERX_REGS_VH
`define UERX_REGS_VH
// ---------------------------------------------------------------
// register offsets (chosen)
// ---------------------------------------------------------------
`define UERX_ADDR_CHEP      4'h0
`define UERX_ADDR_CNTR      4'h1
`define UERX_ADDR_EVT       4'h2
// ---------------------------------------------------------------
// endpoint_channel_control fields
// ---------------------------------------------------------------
`define UERX_TADDR_LSB      16
`define UERX_TADDR_MSB      22
`define UERX_RXDONE_BIT     15
`define UERX_RXTOG_BIT      14
`define UERX_RXSTAT_LSB     12
`define UERX_RXSTAT_MSB     13
`define UERX_SETUP_BIT      11
`define UERX_EPTYPE_LSB     9
`define UERX_EPTYPE_MSB     10
`define UERX_KIND_BIT       8
`define UERX_TXDONE_BIT     7
`define UERX_TXTOG_BIT      6
// ---------------------------------------------------------------
// controller control fields (chosen)
// ---------------------------------------------------------------
`define UERX_CNTR_HOST_BIT  0
`define UERX_CNTR_DONEIE_BIT 1
`define UERX_CNTR_RST_BIT   2
// ---------------------------------------------------------------
// encodings
// ---------------------------------------------------------------
`define UERX_ST_DIS         2'h0
`define UERX_ST_STALL       2'h1
`define UERX_ST_NAK         2'h2
`define UERX_ST_VALID       2'h3
`define UERX_TY_BULK        2'h0
`define UERX_TY_CTRL        2'h1
`define UERX_TY_ISO         2'h2
`define UERX_TY_INT         2'h3
// link-side result codes
`define UERX_RES_ACK        2'h0
`define UERX_RES_NAK        2'h1
`define UERX_RES_STALL      2'h2
`define UERX_RES_ERR        2'h3
`define UERX_RESET_VAL      32'h0000_0000
`endif

// File: verilog/uerx_sync.v
// two-flop synchroniser for the bus-reset level from the pin side
module uerx_sync (
   input  wire mclk,  // clock
   input  wire rst,   // async reset
   input  wire d,     // asynchronous level
   output reg  q      // synchronised level
);
   reg meta;
   // ---------------------------------------------------------------
   // two stages, first one read only by the second
   // ---------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         q    <= 1'b0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// File: verilog/uerx_chan.v
// receive side and configuration of one usb endpoint / host channel
//
// Local design decisions: the strobed register port and the register addresses.
`include "uerx_regs.vh"
module uerx_chan (
   input  wire        mclk,         // 10 MHz clock
   input  wire        rst,          // async reset, active high
   input  wire [3:0]  addr,         // register word index
   input  wire [31:0] wdata,        // write data
   input  wire        wr,           // write strobe
   input  wire        rd,           // read strobe
   output reg  [31:0] rdata,        // read data, cycle after rd
   input  wire        usb_reset_pin,// bus reset seen on the line (async)
   input  wire        sof,          // start of frame pulse
   input  wire        rx_end,       // reception / IN transaction ended
   input  wire        rx_is_setup,  // ended token was SETUP
   input  wire [1:0]  rx_result,    // outcome of the transaction
   input  wire        rx_pid,       // data PID received (0 DATA0)
   input  wire        tx_setup_ack, // host: SETUP acknowledged
   input  wire        tx_done_set,  // tx transaction done event
   output reg  [6:0]  target_device_address, // host target address
   output reg         rx_handshake, // device: give handshake to rx
   output reg  [1:0]  rx_reply,     // device: reply code for token
   output reg         issue_req,    // host: channel requests a slot
   output reg         ep_irq,       // endpoint interrupt condition
   output reg         gen_irq       // generic controller interrupt
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg        rx_transaction_done;
   reg        tx_transaction_done;
   reg        rx_data_toggle;
   reg        tx_data_toggle;
   reg [1:0]  rx_status;
   reg        setup_bit;
   reg [1:0]  endpoint_type;
   reg        endpoint_kind_bit;
   reg        host_mode;
   reg        transfer_done_irq_enable;
   reg        forced_bus_reset;
   reg        running;       // host: transaction under way
   reg        aborted;       // host: running one was disabled
   reg        buf_owed;      // host dbl buffer awaiting release
   reg        tx_tog_seen;   // tx toggle at last ACK
   reg [24:0] rsvd_hi;       // other rw bits held as stored
   wire       bus_reset;
   wire       clr_all;

   uerx_sync u_sync (
      .mclk (mclk),
      .rst  (rst),
      .d    (usb_reset_pin),
      .q    (bus_reset)
   );

   assign clr_all = bus_reset | forced_bus_reset;

   // decoded helpers
   function is_type;
      input [1:0] t;
      input [1:0] want;
      begin
         is_type = (t == want);
      end
   endfunction

   wire is_ctrl = is_type(endpoint_type, `UERX_TY_CTRL);
   wire is_iso  = is_type(endpoint_type, `UERX_TY_ISO);
   wire dbl_buf = is_type(endpoint_type, `UERX_TY_BULK) & endpoint_kind_bit;
   wire w_chep  = wr & (addr == `UERX_ADDR_CHEP);
   wire w_cntr  = wr & (addr == `UERX_ADDR_CNTR);
   // setup on non-control is dropped; in host mode it still ends a running transaction
   wire setup_ok = ~rx_is_setup | is_ctrl;
   wire ev       = rx_end & setup_ok;
   wire ack      = (rx_result == `UERX_RES_ACK);
   wire pid_ok   = (rx_pid == rx_data_toggle);
   // device success: stall still lets setup through, NAK drops it
   wire dev_ok   = ~host_mode & ev & ack &
                   (rx_is_setup ? (rx_status == `UERX_ST_STALL ||
                                   rx_status == `UERX_ST_VALID)
                                : (rx_status == `UERX_ST_VALID) &
                                  (is_iso | pid_ok));
   wire host_ev  = host_mode & ev & running & ~aborted;

   // ---------------------------------------------------------------
   // device-side token reply (combinational next, flopped out)
   // ---------------------------------------------------------------
   reg       next_hs;
   reg [1:0] next_reply;
   always @* begin
      next_hs    = 1'b0;
      next_reply = `UERX_RES_ACK;
      // a corrupted packet is never answered
      if (!host_mode && rx_end && setup_ok &&
          rx_result != `UERX_RES_ERR) begin
         if (rx_is_setup) begin
            // SETUP cannot be NAKed: stay silent like a bad packet
            next_hs    = (rx_status != `UERX_ST_NAK) &&
                         (rx_status != `UERX_ST_DIS);
            next_reply = `UERX_RES_ACK;
         end else begin
            case (rx_status)
               `UERX_ST_STALL: begin
                  next_hs    = 1'b1;
                  next_reply = `UERX_RES_STALL;
               end
               `UERX_ST_NAK: begin
                  next_hs    = 1'b1;
                  next_reply = `UERX_RES_NAK;
               end
               `UERX_ST_VALID: begin
                  next_hs    = ~is_iso;
                  next_reply = `UERX_RES_ACK;
               end
               default: begin
                  next_hs    = 1'b0;
                  next_reply = `UERX_RES_ACK;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // controller control bits
   // ---------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         host_mode                <= 1'b0;
         transfer_done_irq_enable <= 1'b0;
         forced_bus_reset         <= 1'b0;
      end else if (w_cntr) begin
         host_mode                <= wdata[`UERX_CNTR_HOST_BIT];
         transfer_done_irq_enable <= wdata[`UERX_CNTR_DONEIE_BIT];
         forced_bus_reset         <= wdata[`UERX_CNTR_RST_BIT];
      end
   end

   // ---------------------------------------------------------------
   // done flags: set wins over the software clear, kept on bus reset
   // ---------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_transaction_done <= 1'b0;
         tx_transaction_done <= 1'b0;
      end else begin
         if (dev_ok | host_ev)
            rx_transaction_done <= 1'b1;
         else if (w_chep && !wdata[`UERX_RXDONE_BIT])
            rx_transaction_done <= 1'b0;
         if (tx_done_set)
            tx_transaction_done <= 1'b1;
         else if (w_chep && !wdata[`UERX_TXDONE_BIT])
            tx_transaction_done <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // toggles, status, setup, configuration
   // hardware update first, then software toggle-on-one on top, so a
   // write landing with an event still has its effect
   // ---------------------------------------------------------------
   reg        next_dtog;
   reg [1:0]  next_stat;
   reg        next_setup;
   reg        next_run;
   reg        next_abort;
   reg        next_owed;
   always @* begin
      next_dtog  = rx_data_toggle;
      next_stat  = rx_status;
      next_setup = setup_bit;
      next_run   = running;
      next_abort = aborted;
      next_owed  = buf_owed;
      if (!host_mode) begin
         if (dev_ok) begin
            if (rx_is_setup)
               next_dtog = 1'b0;
            else
               next_dtog = ~rx_data_toggle;
            if (!is_iso)
               next_stat = `UERX_ST_NAK;
         end else if (ev && is_iso && !rx_is_setup &&
                      rx_status == `UERX_ST_VALID)
            next_dtog = ~rx_data_toggle;
         if (dev_ok && is_ctrl && !rx_transaction_done)
            next_setup = rx_is_setup;
      end else begin
         // host: frame start revalidates a naked channel
         if (sof && rx_status == `UERX_ST_NAK)
            next_stat = `UERX_ST_VALID;
         if (issue_req && sof)
            next_run = 1'b1;
         if (rx_end && running) begin
            next_run   = 1'b0;
            next_abort = 1'b0;
            if (!aborted) begin
               case (rx_result)
                  `UERX_RES_ACK: begin
                     if (!is_iso)
                        next_dtog = ~rx_data_toggle;
                     if (rx_is_setup)
                        next_dtog = 1'b0;
                     if (dbl_buf)
                        next_owed = 1'b1;
                     else if (!is_iso)
                        next_stat = `UERX_ST_DIS;
                  end
                  `UERX_RES_NAK:   next_stat = `UERX_ST_NAK;
                  `UERX_RES_STALL: next_stat = `UERX_ST_STALL;
                  default:         next_stat = rx_status;
               endcase
            end
         end
         if (tx_setup_ack)
            next_setup = 1'b0;
         if (tx_data_toggle != tx_tog_seen)
            next_owed = 1'b0;
      end
      if (w_chep) begin
         next_dtog = next_dtog ^ wdata[`UERX_RXTOG_BIT];
         next_stat = next_stat ^
                     wdata[`UERX_RXSTAT_MSB:`UERX_RXSTAT_LSB];
         if (host_mode) begin
            if (is_ctrl)
               next_setup = wdata[`UERX_SETUP_BIT];
            if (rx_status == `UERX_ST_VALID &&
                next_stat == `UERX_ST_DIS && running)
               next_abort = 1'b1;
         end
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_data_toggle        <= 1'b0;
         tx_data_toggle        <= 1'b0;
         rx_status             <= `UERX_ST_DIS;
         setup_bit             <= 1'b0;
         endpoint_type         <= `UERX_TY_BULK;
         endpoint_kind_bit     <= 1'b0;
         target_device_address <= 7'h00;
         running               <= 1'b0;
         aborted               <= 1'b0;
         buf_owed              <= 1'b0;
         tx_tog_seen           <= 1'b0;
      end else if (clr_all) begin
         rx_data_toggle        <= 1'b0;
         tx_data_toggle        <= 1'b0;
         rx_status             <= `UERX_ST_DIS;
         setup_bit             <= 1'b0;
         endpoint_type         <= `UERX_TY_BULK;
         endpoint_kind_bit     <= 1'b0;
         target_device_address <= 7'h00;
         running               <= 1'b0;
         aborted               <= 1'b0;
         buf_owed              <= 1'b0;
         tx_tog_seen           <= 1'b0;
      end else begin
         rx_data_toggle <= next_dtog;
         rx_status      <= next_stat;
         setup_bit      <= next_setup;
         running        <= next_run;
         aborted        <= next_abort;
         buf_owed       <= next_owed;
         if (next_owed && !buf_owed)
            tx_tog_seen <= tx_data_toggle;
         if (w_chep) begin
            tx_data_toggle <= tx_data_toggle ^ wdata[`UERX_TXTOG_BIT];
            endpoint_type  <= wdata[`UERX_EPTYPE_MSB:`UERX_EPTYPE_LSB];
            endpoint_kind_bit <= wdata[`UERX_KIND_BIT];
            target_device_address <=
               wdata[`UERX_TADDR_MSB:`UERX_TADDR_LSB];
         end
      end
   end

   // other writable bits (tx status, endpoint number) kept for readback
   always @(posedge mclk or posedge rst) begin
      if (rst)
         rsvd_hi <= 25'h000_0000;
      else if (clr_all)
         rsvd_hi <= 25'h000_0000;
      else if (w_chep)
         rsvd_hi <= {19'h0_0000, wdata[5:0]};
   end

   // ---------------------------------------------------------------
   // outputs, all flopped
   // ---------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_handshake <= 1'b0;
         rx_reply     <= `UERX_RES_ACK;
         issue_req    <= 1'b0;
         ep_irq       <= 1'b0;
         gen_irq      <= 1'b0;
      end else begin
         rx_handshake <= next_hs;
         rx_reply     <= next_reply;
         // suspended double buffer simply stops asking
         issue_req    <= host_mode & (next_stat == `UERX_ST_VALID) &
                         ~next_run & ~next_owed & ~clr_all;
         ep_irq       <= rx_transaction_done;
         gen_irq      <= rx_transaction_done &
                         transfer_done_irq_enable;
      end
   end

   // ---------------------------------------------------------------
   // register read, data in the cycle after rd
   // ---------------------------------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst)
         rdata <= `UERX_RESET_VAL;
      else if (rd) begin
         case (addr)
            `UERX_ADDR_CHEP:
               rdata <= {9'h000, target_device_address,
                         rx_transaction_done, rx_data_toggle, rx_status,
                         setup_bit, endpoint_type, endpoint_kind_bit,
                         tx_transaction_done, tx_data_toggle,
                         rsvd_hi[5:0]};
            `UERX_ADDR_CNTR:
               rdata <= {29'h0000_0000, forced_bus_reset,
                         transfer_done_irq_enable, host_mode};
            `UERX_ADDR_EVT:
               rdata <= {28'h000_0000, aborted, buf_owed, running,
                         bus_reset};
            default:
               rdata <= `UERX_RESET_VAL;
         endcase
      end else
         rdata <= `UERX_RESET_VAL;
   end
endmodule

// File: test/uerx_chan_checker.sv
// assertion checker for the endpoint rx channel, bound to its ports
`include "uerx_regs.vh"
module uerx_chan_checker (
   input wire        mclk,                  // clock
   input wire        rst,                   // async reset
   input wire        wr,                    // write strobe
   input wire        sof,                   // frame start
   input wire        rx_end,                // token ended
   input wire [1:0]  rx_result,             // token outcome
   input wire        usb_reset_pin,         // bus reset level
   input wire [6:0]  target_device_address, // host address
   input wire        rx_handshake,          // handshake pulse
   input wire [1:0]  rx_reply,              // reply code
   input wire        issue_req,             // slot request
   input wire        ep_irq,                // endpoint irq
   input wire        gen_irq                // generic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // ---------------------------------------------------------------
   // irq, handshake, target address and slot request timing against their causes
   // ---------------------------------------------------------------
   AST_GEN_NEEDS_EP: assert property (gen_irq |-> ep_irq)
      else $error("generic irq without endpoint irq");
   AST_GEN_RISE: assert property (
      $rose(gen_irq) |-> $rose(ep_irq) || $past(wr, 2))
      else $error("generic irq rose without cause");
   AST_EP_RISE: assert property ($rose(ep_irq) |-> $past(rx_end, 2))
      else $error("endpoint irq rose without a transaction");
   // done flag survives bus reset, only software clears it
   AST_EP_FALL: assert property ($fell(ep_irq) |-> $past(wr, 2))
      else $error("endpoint irq fell without a write");
   AST_HS_CAUSE: assert property (
      rx_handshake |-> $past(rx_end) && $past(rx_result) != `UERX_RES_ERR)
      else $error("handshake without a clean token");
   AST_HS_PULSE: assert property (
      rx_handshake && !rx_end |=> !rx_handshake)
      else $error("handshake longer than one cycle");
   AST_TDA: assert property (
      $changed(target_device_address) |-> $past(wr) || $past(wr, 2)
      || $past(usb_reset_pin, 3) || $past(usb_reset_pin, 4))
      else $error("target address changed by itself");
   AST_ISSUE_RISE: assert property (
      $rose(issue_req) |-> $past(wr) || $past(wr, 2) || $past(sof)
      || $past(sof, 2) || $past(rx_end) || $past(rx_end, 2))
      else $error("channel asked for a slot without cause");
   // main scenarios reached
   cover property ($rose(ep_irq));
   cover property ($rose(gen_irq));
   cover property (rx_handshake && rx_reply == `UERX_RES_STALL);
   cover property ($rose(issue_req));
endmodule

bind uerx_chan uerx_chan_checker u_chk (.mclk, .rst, .wr, .sof, .rx_end,
   .rx_result, .usb_reset_pin, .target_device_address, .rx_handshake,
   .rx_reply, .issue_req, .ep_irq, .gen_irq);

// File: test/uerx_usb_peer.sv
// behavioural usb peer on the link side of the endpoint rx channel
module uerx_usb_peer (
   input  wire        mclk,         // clock
   output logic       sof,          // frame start pulse
   output logic       rx_end,       // token ended
   output logic       rx_is_setup,  // token was setup
   output logic [1:0] rx_result,    // token outcome
   output logic       rx_pid,       // data pid
   output logic       tx_setup_ack, // setup acknowledged
   output logic       tx_done_set   // tx done event
);
   timeunit 1ns;
   timeprecision 1ns;
   // quiet link at start
   initial begin
      sof = 1'b0;
      rx_end = 1'b0;
      rx_is_setup = 1'b0;
      rx_result = 2'h3;
      rx_pid = 1'b0;
      tx_setup_ack = 1'b0;
      tx_done_set = 1'b0;
   end
   // one token, after lag idle cycles; released qualifiers show the
   // inverse so a stale value never passes for a fresh one
   task automatic txn(input logic su, input logic [1:0] res,
                      input logic pid, input int lag);
      repeat (lag) @(posedge mclk);
      @(posedge mclk);
      rx_end <= 1'b1;
      rx_is_setup <= su;
      rx_result <= res;
      rx_pid <= pid;
      @(posedge mclk);
      rx_end <= 1'b0;
      rx_is_setup <= ~su;
      rx_result <= ~res;
      rx_pid <= ~pid;
   endtask
   // start of frame marker
   task automatic frame();
      @(posedge mclk);
      sof <= 1'b1;
      @(posedge mclk);
      sof <= 1'b0;
   endtask
endmodule

// File: test/usb_endpoint_rx_channel_control_tb.sv
// self-checking bench for the endpoint rx channel
`include "uerx_regs.vh"
module usb_endpoint_rx_channel_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] ALL = 32'h007F_FE00; // fields owned here
   localparam logic [31:0] HM = 32'h007F_BE00;  // host: toggle ignored
   logic        mclk;
   logic        rst;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic        usb_reset_pin;
   wire  [31:0] rdata;
   wire  [6:0]  target_device_address;
   wire  [1:0]  rx_result, rx_reply;
   wire         sof, rx_end, rx_is_setup, rx_pid, tx_setup_ack, tx_done_set;
   wire         rx_handshake, issue_req, ep_irq, gen_irq;
   logic [1:0]  mst, mty;
   logic        mtog, mdone, msu;
   logic [6:0]  mad;
   logic [31:0] v;
   int          n_mismatch, tests_run, k;
   logic [1:0]  st_t [5] = '{`UERX_ST_NAK, `UERX_ST_STALL, `UERX_ST_VALID,
                             `UERX_ST_DIS, `UERX_ST_VALID};
   logic [1:0]  rs_t [5] = '{`UERX_RES_ACK, `UERX_RES_ACK, `UERX_RES_ERR,
                             `UERX_RES_ACK, `UERX_RES_ACK};
   logic [2:0]  hs_t [4] = '{{1'b1, `UERX_RES_NAK}, {1'b1, `UERX_RES_STALL},
                             3'h0, 3'h0};
   logic [1:0]  sh_t [4] = '{`UERX_ST_DIS, `UERX_ST_NAK, `UERX_ST_STALL,
                             `UERX_ST_VALID};

   uerx_chan dut (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata,
      .usb_reset_pin, .sof, .rx_end, .rx_is_setup, .rx_result, .rx_pid,
      .tx_setup_ack, .tx_done_set, .target_device_address, .rx_handshake,
      .rx_reply, .issue_req, .ep_irq, .gen_irq);
   uerx_usb_peer peer (.mclk, .sof, .rx_end, .rx_is_setup, .rx_result,
      .rx_pid, .tx_setup_ack, .tx_done_set);

   // ---------------------------------------------------------------
   // bus cycles, model and comparison
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("mismatches %0d of %0d compares", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   function automatic logic [31:0] exp_reg();
      return {9'h0, mad, mdone, mtog, mst, msu, mty, 9'h0};
   endfunction
   task automatic chk_reg(input logic [31:0] m);
      logic [31:0] r;
      rd_reg(`UERX_ADDR_CHEP, r);
      chk(r & m, exp_reg() & m);
   endtask
   // status and toggle are written as flips from the modelled value
   task automatic prog(input logic [1:0] ty, input logic [1:0] st,
                       input logic tg);
      wr_reg(`UERX_ADDR_CHEP,
             {9'h0, mad, 1'b1, mtog ^ tg, mst ^ st, 1'b0, ty, 9'h0});
      mty = ty;
      mst = st;
      mtog = tg;
   endtask
   task automatic clr();
      wr_reg(`UERX_ADDR_CHEP, {9'h0, mad, 5'h0, mty, 9'h0});
      mdone = 1'b0;
   endtask
   task automatic wait_issue();
      int i;
      for (i = 0; i < 20 && issue_req !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      chk({31'h0, issue_req}, 32'h0000_0001);
      if (i == 20) begin
         final_report();
      end
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog and scenarios
   // ---------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      final_report();
   end
   initial begin
      {rst, addr, wdata, wr, rd, usb_reset_pin} = {1'b1, 39'h0};
      {mst, mty, mtog, mdone, msu, mad, n_mismatch, tests_run} = '0;
      k = $urandom(9);
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      rd_reg(`UERX_ADDR_CHEP, v);
      chk(v, `UERX_RESET_VAL);
      rd_reg(4'hF, v);
      chk(v, 32'h0000_0000);
      // random field writes: flips, plain loads, done ignores a one
      for (k = 0; k < 8; k++) begin
         v = $urandom & 32'h007F_F600;
         wr_reg(`UERX_ADDR_CHEP, v);
         mad = v[22:16];
         mtog = mtog ^ v[14];
         mst = mst ^ v[13:12];
         mty = v[10:9];
         chk_reg(ALL);
         chk({25'h0, target_device_address}, {25'h0, mad});
      end
      // device out accepted, then cleared by software
      wr_reg(`UERX_ADDR_CNTR, 32'h0000_0002);
      prog(`UERX_TY_BULK, `UERX_ST_VALID, 1'b0);
      peer.txn(1'b0, `UERX_RES_ACK, 1'b0, 0);
      #1 chk({29'h0, rx_handshake, rx_reply}, 32'h0000_0004);
      {mdone, mtog, mst} = {2'b11, `UERX_ST_NAK};
      chk_reg(ALL);
      chk({30'h0, ep_irq, gen_irq}, 32'h0000_0003);
      clr();
      chk_reg(ALL);
      chk({31'h0, ep_irq}, 32'h0000_0000);
      // tokens that must not complete
      for (k = 0; k < 5; k++) begin
         prog(`UERX_TY_BULK, st_t[k], mtog);
         peer.txn(1'b0, rs_t[k], mtog ^ (k == 4), 0);
         #1 v = {29'h0, rx_handshake, rx_handshake ? rx_reply : 2'b00};
         if (k < 4) chk(v, {29'h0, hs_t[k]});
         chk_reg(ALL);
      end
      // setup beats stall, clears toggle, then stays frozen
      prog(`UERX_TY_CTRL, `UERX_ST_STALL, 1'b1);
      peer.txn(1'b1, `UERX_RES_ACK, 1'b0, 0);
      #1 chk({31'h0, rx_handshake}, 32'h0000_0001);
      {mdone, msu, mtog, mst} = {3'b110, `UERX_ST_NAK};
      chk_reg(ALL);
      prog(`UERX_TY_CTRL, `UERX_ST_NAK, 1'b1);
      peer.txn(1'b1, `UERX_RES_ACK, 1'b0, 2);
      #1 chk({31'h0, rx_handshake}, 32'h0000_0000);
      chk_reg(ALL);
      clr();
      prog(`UERX_TY_CTRL, `UERX_ST_VALID, 1'b0);
      peer.txn(1'b0, `UERX_RES_ACK, 1'b0, 0);
      {mdone, msu, mtog, mst} = {3'b101, `UERX_ST_NAK};
      chk_reg(ALL);
      clr();
      prog(`UERX_TY_BULK, `UERX_ST_VALID, mtog);
      peer.txn(1'b1, `UERX_RES_ACK, mtog, 0);
      #1 chk({31'h0, rx_handshake}, 32'h0000_0000);
      chk_reg(ALL);
      prog(`UERX_TY_ISO, `UERX_ST_VALID, 1'b0);
      peer.txn(1'b0, `UERX_RES_ACK, 1'b0, 0);
      {mdone, mtog} = 2'b11;
      chk_reg(ALL);
      clr();
      // host: every in ending sets done; ack, nak and stall show in the status, error leaves it valid
      wr_reg(`UERX_ADDR_CNTR, 32'h0000_0003);
      for (k = 0; k < 4; k++) begin
         prog(`UERX_TY_BULK, `UERX_ST_VALID, mtog);
         wait_issue();
         peer.frame();
         peer.txn(1'b0, k[1:0], mtog, 1);
         {mdone, mst} = {1'b1, sh_t[k]};
         chk_reg(HM);
         clr();
      end
      // nak parks the channel until the next frame
      peer.frame();
      peer.txn(1'b0, `UERX_RES_NAK, mtog, 1);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, issue_req}, 32'h0000_0000);
      peer.frame();
      {mdone, mst} = {1'b1, `UERX_ST_VALID};
      chk_reg(HM);
      wait_issue();
      clr();
      // abort while running: bus finishes, no done flag
      peer.frame();
      prog(`UERX_TY_BULK, `UERX_ST_DIS, mtog);
      peer.txn(1'b0, `UERX_RES_ACK, mtog, 0);
      chk_reg(HM);
      // bus reset with a pending completion
      prog(`UERX_TY_BULK, `UERX_ST_VALID, mtog);
      wait_issue();
      peer.frame();
      peer.txn(1'b0, `UERX_RES_NAK, mtog, 1);
      usb_reset_pin <= 1'b1;
      repeat (5) @(posedge mclk);
      usb_reset_pin <= 1'b0;
      repeat (3) @(posedge mclk);
      {mad, mtog, mst, msu, mty, mdone} = 14'h0001;
      chk_reg(ALL);
      chk({25'h0, target_device_address}, 32'h0000_0000);
      final_report();
   end
endmodule
